// *** logic/edb_defines.vh ***
// Constants for the external data bus and grant port
//
// Contract
// RULE1 - Drive a 14-bit address on every external data access.
// RULE2 - Data transfers use only upper 16 of 24 data lines.
// RULE3 - Assert data-space select during each external data access.
// RULE4 - Assert write strobe only during write accesses.
// RULE5 - Assert read strobe only during read accesses.
// RULE6 - 2K words from 0x3000 are on-chip RAM, never external.
// RULE7 - 0x3800 to 0x3FFF are internal control registers.
// RULE8 - Remaining 12K words are three external zones with own wait states.
// RULE9 - All zones use 7 wait states after reset.
// RULE10 - Two extra wait fields exist but never affect timing.
// RULE11 - Idle bus request: next cycle float outputs, grant, halt.
// RULE12 - Go mode keeps executing until an external access is needed; the port also stalls internal data accesses in GRANT.
// RULE13 - Request during access: grant the cycle after it completes.
// RULE14 - Grant may fall between two accesses of one instruction.
// RULE15 - Request release: drop grant, drive outputs, resume where halted.
// RULE16 - Bus request honoured always, even during reset or boot.
// RULE17 - Assert grant-hang when an access is blocked by the grant.
// RULE18 - After bus return, do pending access, then drop grant-hang.
// RULE19 - Outside master releases request on seeing grant-hang.
// RULE20 - ROM-enable bit enables program ROM when 1.
// RULE21 - Writers put zeros in reserved bits.
// RULE22 - Control registers reached only by data reads and writes.
// RULE23 - Outside parts qualify strobes with the space select.
// RULE24 - Zone wait fields are 3 bits, 0 to 7 extra cycles.
`ifndef EDB_DEFINES_VH
`define EDB_DEFINES_VH
`define EDB_RAM_BASE 14'h3000
`define EDB_REG_BASE 14'h3800
`define EDB_WAIT_REG 14'h3ffe
`define EDB_WAIT_RESET 16'h7fff
`define EDB_WAIT_MASK 16'hffff
`define EDB_ROM_BIT 15
`define EDB_ZONE1_BASE 14'h1000
`define EDB_ZONE2_BASE 14'h2000
`define EDB_ZONE_COUNT 3
`define EDB_ZONE_FIELD_W 3
`define EDB_ZONE_LSB 12
`endif

// *** logic/edb_grant_port.v ***
// External data-memory port with zone wait states and bus hand-off
`include "edb_defines.vh"
`default_nettype none
module edb_grant_port #(
    parameter AW = 14,
    parameter DW = 24
) (
    // Clock, reset, enable
    input wire clock,
    input wire arst_n,
    input wire clkEn,
    // Core access request
    input wire coreReq,
    input wire coreWrite,
    input wire [AW-1:0] coreAddr,
    input wire [15:0] coreWdata,
    input wire goMode,
    output reg coreDone,
    output reg [15:0] coreRdata,
    output reg coreHalt,
    output reg romEnable,
    // External pins
    output reg [AW-1:0] addrOut,
    output reg addrOe,
    output reg [DW-1:0] dataOut,
    output reg dataOe,
    input wire [DW-1:0] dataIn,
    output reg data_space_select_n,
    output reg read_strobe_n,
    output reg write_strobe_n,
    output reg strobeOe,
    input wire ext_bus_req_n,
    output reg ext_bus_granted_n,
    output reg grant_hang_n
);
    // Overview
    // - Core requests arrive as a level held until coreDone pulses.
    // - Internal RAM and the control-register area end the access at once when no grant is due.
    // - External zones drive address, select and one strobe for wait+1 cycles.
    // - A master pulling the request pin low gets the bus between accesses.
    // - An external core access blocked by a grant pulls the hang pin low until done.
    //
    // Timing limits
    // - Request pin passes two flops, so a grant comes on the third edge.
    // - Read data also passes two flops; zones used for reads need wait >= 2.
    // - Only one access is outstanding; coreDone must fall before the next.
    //
    // Clock enable
    // - Every flop holds while clkEn is low, the grant flops included.
    //
    // Reset
    // - The sequencer clears and the control register loads 7fff at once.
    // - Grant and float flops have no reset, so a master keeps the bus.

    // Sequencer states
    localparam IDLE = 2'h0; // Waiting for core or master
    localparam EXT = 2'h1; // External access with select and one strobe low
    localparam GRANT = 2'h2; // Bus floated and handed to a master

    // Sequencer state and access timing
    reg [1:0] state;
    reg [2:0] waitCnt;

    // Wait-state and ROM control register
    reg [15:0] zone_wait_control;

    // Pin synchronisers
    reg reqSync1;
    reg reqSync2;
    reg [15:0] rdSync1;
    reg [15:0] rdSync2;

    // A hung access is owed once the bus comes back
    reg pendDone;

    // Address decode of the core request
    wire busReq = ~reqSync2;
    wire inRam = (coreAddr >= `EDB_RAM_BASE) && (coreAddr < `EDB_REG_BASE); // RULE6
    wire inRegs = (coreAddr >= `EDB_REG_BASE); // RULE7
    wire isExt = ~inRam & ~inRegs; // RULE8
    wire isWaitReg = (coreAddr == `EDB_WAIT_REG);

    // Wait count of the zone that the address falls in
    reg [2:0] zoneWait;
    wire [3*`EDB_ZONE_COUNT-1:0] zoneMasked;

    // Grant follows the request everywhere but inside an external access
    wire next_grant = busReq && (state != EXT); // RULE13 RULE14 RULE16

    // One slice per zone: match the top address bits, pass its field.
    // Fields 3 and 4 have no slice, so they never steer timing.
    genvar z;
    generate
        for (z = 0; z < `EDB_ZONE_COUNT; z = z + 1)
        begin : zoneSlice
            localparam [1:0] ZONE_ID = z;
            wire zoneHit = (coreAddr[`EDB_ZONE_LSB+1:`EDB_ZONE_LSB] == ZONE_ID); // RULE8
            assign zoneMasked[z*`EDB_ZONE_FIELD_W +: `EDB_ZONE_FIELD_W] =
                zoneHit ? zone_wait_control[z*`EDB_ZONE_FIELD_W +: `EDB_ZONE_FIELD_W] : 3'h0; // RULE24
        end
    endgenerate

    // Only one slice is ever non-zero, so an OR merges them
    always @*
    begin
        zoneWait = zoneMasked[2:0] | zoneMasked[5:3] | zoneMasked[8:6]; // RULE10
    end

    // Request pin passes two flops with no reset, so it is seen in reset
    always @(posedge clock)
    begin
        if (clkEn)
        begin
            reqSync1 <= ext_bus_req_n;
            reqSync2 <= reqSync1;
        end
    end

    // Upper data lines pass two flops before the read data register
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdSync1 <= 16'h0000;
            rdSync2 <= 16'h0000;
        end
        else if (clkEn)
        begin
            rdSync1 <= dataIn[DW-1:DW-16]; // RULE2
            rdSync2 <= rdSync1;
        end
    end

    // Grant and float flops carry no reset: the sequencer sits in IDLE
    // during reset, so next_grant then follows the request pin alone.
    // The cost is an unknown grant until the third clock edge after power-up.
    always @(posedge clock)
    begin
        if (clkEn)
        begin
            ext_bus_granted_n <= ~next_grant; // RULE11 RULE15 RULE16
            addrOe <= ~next_grant; // RULE11
            strobeOe <= ~next_grant; // RULE11 RULE15
        end
    end

    // Main sequencer
    // - IDLE hands the bus over before starting any new access.
    // - EXT holds address, select and strobe until the count runs out.
    // - GRANT stalls external requests and raises the hang flag.
    // An access owed from GRANT runs first after release, then hang drops.
    // Internal accesses finish in one cycle from IDLE, wait out GRANT, and never touch the pins.
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= IDLE;
            waitCnt <= 3'h0;
            zone_wait_control <= `EDB_WAIT_RESET; // RULE9
            romEnable <= 1'b0;
            coreDone <= 1'b0;
            coreRdata <= 16'h0000;
            coreHalt <= 1'b0;
            addrOut <= {AW{1'b0}};
            dataOut <= {DW{1'b0}};
            dataOe <= 1'b0;
            data_space_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            grant_hang_n <= 1'b1;
            pendDone <= 1'b0;
        end
        else if (clkEn)
        begin
            coreDone <= 1'b0;
            case (state)
                IDLE:
                begin
                    if (busReq)
                    begin
                        // Grant between accesses, not at instruction end
                        state <= GRANT; // RULE11 RULE14 RULE16
                        dataOe <= 1'b0;
                        coreHalt <= ~goMode; // RULE12
                    end
                    else if (coreReq && !coreDone && isExt)
                    begin
                        state <= EXT;
                        waitCnt <= zoneWait; // RULE24
                        addrOut <= coreAddr; // RULE1
                        data_space_select_n <= 1'b0; // RULE3
                        read_strobe_n <= coreWrite; // RULE5
                        write_strobe_n <= ~coreWrite; // RULE4
                        dataOut <= {coreWdata, 8'h00}; // RULE2
                        dataOe <= coreWrite;
                        coreHalt <= 1'b1;
                    end
                    else if (coreReq && !coreDone)
                    begin
                        // Internal RAM is outside this block; registers here
                        coreDone <= 1'b1; // RULE22
                        if (isWaitReg && coreWrite)
                        begin
                            zone_wait_control <= coreWdata & `EDB_WAIT_MASK;
                            romEnable <= coreWdata[`EDB_ROM_BIT]; // RULE20
                        end
                        coreRdata <= isWaitReg ?
                            {romEnable, zone_wait_control[14:0]} : 16'h0000;
                    end
                end
                EXT:
                begin
                    // Strobes hold for all wait cycles, up to eight in all
                    if (waitCnt != 3'h0)
                        waitCnt <= waitCnt - 3'h1;
                    else
                    begin
                        state <= IDLE; // RULE13
                        coreDone <= 1'b1;
                        coreHalt <= 1'b0;
                        coreRdata <= rdSync2;
                        data_space_select_n <= 1'b1;
                        read_strobe_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        dataOe <= 1'b0;
                        if (pendDone)
                        begin
                            grant_hang_n <= 1'b1; // RULE18
                            pendDone <= 1'b0;
                        end
                    end
                end
                GRANT:
                begin
                    if (!busReq)
                    begin
                        // Resume: outputs driven again, halted access retried
                        state <= IDLE; // RULE15
                        coreHalt <= 1'b0;
                        pendDone <= ~grant_hang_n;
                    end
                    else if (coreReq && isExt)
                    begin
                        grant_hang_n <= 1'b0; // RULE17
                        coreHalt <= 1'b1;
                    end
                end
                default:
                    state <= IDLE;
            endcase
        end
    end
endmodule // edb_grant_port
`default_nettype wire

// *** tb/edb_grant_port_chk.sv ***
// Pin assertions for the data port
`default_nettype none
module edb_grant_port_chk (
    // Watched ports
    input wire logic clock, arst_n, coreDone, addrOe, dataOe, strobeOe, grant_hang_n,
    input wire logic data_space_select_n, read_strobe_n, write_strobe_n, ext_bus_req_n, ext_bus_granted_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int reqCnt;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // Request-low cycles, saturating so it never wraps
    always @(posedge clock or negedge arst_n)
        if (!arst_n)
            reqCnt <= 0;
        else
            reqCnt <= ext_bus_req_n ? 0 : reqCnt + (reqCnt < 99);
    bus_float_a: assert property (!ext_bus_granted_n |-> !addrOe && !strobeOe && !dataOe)
        else $error("float");
    write_only_a: assert property (!write_strobe_n |-> !data_space_select_n && read_strobe_n)
        else $error("wr");
    read_only_a: assert property (!read_strobe_n |-> !data_space_select_n && write_strobe_n)
        else $error("rd");
    grant_after_a: assert property ($fell(ext_bus_granted_n) |-> $past(data_space_select_n))
        else $error("early");
    grant_bound_a: assert property (reqCnt >= 20 |-> !ext_bus_granted_n)
        else $error("late");
    grant_release_a: assert property (ext_bus_req_n [*4] |-> ext_bus_granted_n)
        else $error("held");
    hang_cause_a: assert property ($fell(grant_hang_n) |-> !ext_bus_granted_n)
        else $error("hang");
    hang_drop_a: assert property ($rose(grant_hang_n) |-> coreDone)
        else $error("drop");
endmodule // edb_grant_port_chk
bind edb_grant_port edb_grant_port_chk edb_grant_port_chk_i (.*);
`default_nettype wire

// *** tb/edb_mem_model.sv ***
// Outside memory and bus master model
`default_nettype none
module edb_mem_model (
    // Pins of the port
    input wire logic clock, want, data_space_select_n, read_strobe_n, write_strobe_n, grant_hang_n,
    input wire logic [13:0] addrOut,
    input wire logic [23:0] dataOut,
    output wire logic [23:0] dataIn,
    output var logic ext_bus_req_n = 1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16384];
    logic tog = 0;
    // Unselected bus toggles, so stale data never passes
    assign dataIn = !data_space_select_n && !read_strobe_n ? {mem[addrOut], 8'h00} : {24{tog}};
    always @(posedge clock)
    begin
        tog <= !tog;
        if (!data_space_select_n && !write_strobe_n)
            mem[addrOut] <= dataOut[23:8];
        ext_bus_req_n <= !want || !grant_hang_n;
    end
endmodule // edb_mem_model
`default_nettype wire

// *** tb/edb_grant_port_tb_top.sv ***
// Bench for the data port
`default_nettype none
module edb_grant_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, arst_n = 0, coreReq = 0, coreWrite = 0, goMode = 0, want = 0;
    logic coreDone, coreHalt, romEnable, addrOe, dataOe, strobeOe, data_space_select_n;
    logic read_strobe_n, write_strobe_n, ext_bus_req_n, ext_bus_granted_n, grant_hang_n;
    logic [13:0] coreAddr = 0, addrOut, a;
    logic [15:0] coreWdata = 0, coreRdata, rd, wd, wr = 16'h7fff;
    logic [23:0] dataIn, dataOut;
    integer errors = 0, cmp_count = 0, seed = 32'h7f59, n, i, k;
    edb_grant_port edb_grant_port_i (.clkEn(1'b1), .*);
    edb_mem_model edb_mem_model_i (.*);
    initial
        forever #50 clock = ~clock;
    task chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Expected select-low cycles: zone field plus one
    function automatic integer span(input logic [13:0] ad);
        return wr[3 * ad[13:12] +: 3] + 1;
    endfunction
    // One core access; n counts cycles with the select low
    task acc(input logic w, input logic [13:0] ad, input logic [15:0] d);
        @(posedge clock);
        coreReq <= 1;
        coreWrite <= w;
        coreAddr <= ad;
        coreWdata <= d;
        n = 0;
        for (i = 0; i < 60 && coreDone !== 1; i++)
        begin
            @(negedge clock);
            n += !data_space_select_n;
        end
        rd = coreRdata;
        if (coreDone !== 1)
        begin
            errors++;
            summarize;
        end
        @(posedge clock);
        coreReq <= 0;
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        arst_n <= 1;
        acc(0, 14'h3ffe, 0);
        chk(rd, 16'h7fff);
        chk(romEnable, 0);
        acc(1, 14'h0abc, 16'h5a5a);
        chk(n, 8);
        // Zones 2, 6 and 3; unused fields random
        wr = {1'b1, 6'($random(seed)), 9'h0f2};
        acc(1, 14'h3ffe, wr);
        acc(0, 14'h3ffe, 0);
        chk(rd, wr);
        chk(romEnable, 1);
        acc(1, 14'h3801, 16'hffff);
        acc(0, 14'h3801, 0);
        chk(rd, 0);
        acc(1, 14'h3123, 16'h1234);
        chk(n, 0);
        $display("register test done");
        // Outside master cuts in at random points
        for (k = 0; k < 16; k++)
        begin
            a = 14'({$random(seed)} % 12288);
            wd = $random(seed);
            want <= $random(seed);
            goMode <= $random(seed);
            acc(1, a, wd);
            chk(n, span(a));
            acc(0, a, 0);
            chk(rd, wd);
            chk(n, span(a));
        end
        $display("zone test done");
        want <= 1;
        for (i = 0; i < 20 && ext_bus_granted_n !== 0; i++)
            @(posedge clock);
        chk(ext_bus_granted_n, 0);
        chk({addrOe, strobeOe, dataOe}, 0);
        chk(coreHalt, !goMode);
        acc(0, 14'h0abc, 0);
        chk(rd, 16'h5a5a);
        chk(grant_hang_n, 1);
        $display("hand-off test done");
        // Reset in mid-run while the master still asks for the bus
        arst_n <= 0;
        for (i = 0; i < 10 && ext_bus_granted_n !== 0; i++)
            @(posedge clock);
        repeat (3) @(posedge clock);
        chk(ext_bus_granted_n, 0);
        want <= 0;
        repeat (6) @(posedge clock);
        chk(ext_bus_granted_n, 1);
        arst_n <= 1;
        acc(0, 14'h3ffe, 0);
        chk(rd, 16'h7fff);
        chk(romEnable, 0);
        $display("reset test done");
        summarize;
    end
endmodule // edb_grant_port_tb_top
`default_nettype wire
